// ==== rtl/adcwin_top.sv ====
// Converter control: conversion timing, tracking, limit registers and window flag.
// Assumes a byte-wide special function register port on the converter clock.
// Contract
// - Compare every new result against limits automatically
// - Window flag readable and drives interrupt
// - Limit order selects inside or outside window
// - Upper limit high byte at c4, resets ones
// - Upper limit low byte at c3
// - Delayed tracking spends three clocks first
// - Conversion takes 13 or 11 clocks
`timescale 1ns/100ps
`include "adcwin_cfg.svh"
module adcwin_top
  import adcwin_pkg::*;
(
  input  wire logic                     CLOCK,
  input  wire logic                     RESETN,
  input  wire logic [7:0]               SFR_ADDR,
  input  wire logic                     SFR_WR,
  input  wire logic [7:0]               SFR_WDATA,
  output logic      [7:0]               SFR_RDATA,
  input  wire adcwin_pkg::adcwin_word_t SAR_RESULT,
  output logic                          TRACK_EN,
  output logic                          SAR_ACTIVE,
  output logic                          CONV_DONE,
  output adcwin_pkg::adcwin_word_t      DATA_OUT,
  output logic                          WINDOW_FLAG
);
  import adcwin_pkg::*;

  adcwin_state_t state_q, state_d;
  logic [7:0]   uh_q, ul_q, lh_q, ll_q;
  logic [3:0]   cnt_q, cnt_d;
  logic         enable_q, track_mode_q, res8_q;
  adcwin_word_t data_q;
  logic         flag_q, done_q;

  // Address match, shared by the write strobes and the read selector.
  function automatic logic adr_hit(input logic [7:0] adr, input logic [7:0] reg_adr);
    adr_hit = adr == reg_adr;
  endfunction : adr_hit

  // Register selects; one decode serves both directions so reads and writes never disagree.
  wire sel_uh  = adr_hit(SFR_ADDR, `ADCWIN_ADDR_UPPER_HIGH);
  wire sel_ul  = adr_hit(SFR_ADDR, `ADCWIN_ADDR_UPPER_LOW);
  wire sel_lh  = adr_hit(SFR_ADDR, `ADCWIN_ADDR_LOWER_HIGH);
  wire sel_ll  = adr_hit(SFR_ADDR, `ADCWIN_ADDR_LOWER_LOW);
  wire sel_ctl = adr_hit(SFR_ADDR, `ADCWIN_ADDR_CONTROL);

  // Register write strobes.
  wire wr_uh  = SFR_WR && sel_uh;
  wire wr_ul  = SFR_WR && sel_ul;
  wire wr_lh  = SFR_WR && sel_lh;
  wire wr_ll  = SFR_WR && sel_ll;
  wire wr_ctl = SFR_WR && sel_ctl;
  wire start  = wr_ctl && SFR_WDATA[`ADCWIN_CTL_START_BIT] && enable_q && state_q == ADCWIN_IDLE;

  // The limit word is right-justified: two bits from the high byte, eight from the low.
  wire adcwin_word_t upper = {uh_q[1:0], ul_q};
  wire adcwin_word_t lower = {lh_q[1:0], ll_q};
  wire [3:0] conv_len = res8_q ? `ADCWIN_CONV8_CLKS : `ADCWIN_CONV10_CLKS;
  wire conv_end = state_q == ADCWIN_CONV && cnt_q == conv_len - 4'h1;
  wire hit;

  adcwin_compare u_cmp (
    .result    (SAR_RESULT),
    .upper_lim (upper),
    .lower_lim (lower),
    .hit       (hit)
  );

  // Conversion sequencer; a start while busy is ignored so a result is never torn.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 4'h1;
    case (state_q)
      ADCWIN_IDLE: begin
        cnt_d = 4'h0;
        if (start) begin
          state_d = track_mode_q ? ADCWIN_TRACK : ADCWIN_CONV;
        end
      end
      ADCWIN_TRACK: begin
        if (cnt_q == `ADCWIN_TRACK_CLKS - 4'h1) begin
          state_d = ADCWIN_CONV;
          cnt_d   = 4'h0;
        end
      end
      ADCWIN_CONV: begin
        if (conv_end) begin
          state_d = ADCWIN_IDLE;
          cnt_d   = 4'h0;
        end
      end
      default: begin
        state_d = ADCWIN_IDLE;
        cnt_d   = 4'h0;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_q <= ADCWIN_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Limit and control registers.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      uh_q         <= `ADCWIN_RST_UPPER_HIGH;
      ul_q         <= `ADCWIN_RST_UPPER_LOW;
      lh_q         <= `ADCWIN_RST_LOWER;
      ll_q         <= `ADCWIN_RST_LOWER;
      enable_q     <= 1'b0;
      track_mode_q <= 1'b0;
      res8_q       <= 1'b0;
    end else begin
      if (wr_uh) uh_q <= SFR_WDATA;
      if (wr_ul) ul_q <= SFR_WDATA;
      if (wr_lh) lh_q <= SFR_WDATA;
      if (wr_ll) ll_q <= SFR_WDATA;
      if (wr_ctl) begin
        enable_q     <= SFR_WDATA[`ADCWIN_CTL_ENABLE_BIT];
        track_mode_q <= SFR_WDATA[`ADCWIN_CTL_TRACK_BIT];
        res8_q       <= SFR_WDATA[`ADCWIN_CTL_RES8_BIT];
      end
    end
  end

  // Result capture and window flag; a hit in the clearing cycle still sets the flag.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      data_q <= 10'h000;
      flag_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= conv_end;
      if (conv_end) data_q <= SAR_RESULT;
      if (conv_end && hit) begin
        flag_q <= 1'b1;
      end else if (wr_ctl && !SFR_WDATA[`ADCWIN_CTL_FLAG_BIT]) begin
        flag_q <= 1'b0;
      end
    end
  end

  // Read mux, registered.
  wire [7:0] ctl_rd = {enable_q, track_mode_q, 1'b0, state_q != ADCWIN_IDLE, flag_q, 2'b00, res8_q};
  wire [7:0] rd_d = sel_uh  ? uh_q :
                    sel_ul  ? ul_q :
                    sel_lh  ? lh_q :
                    sel_ll  ? ll_q :
                    sel_ctl ? ctl_rd : 8'h00;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      SFR_RDATA  <= 8'h00;
      TRACK_EN   <= 1'b0;
      SAR_ACTIVE <= 1'b0;
    end else begin
      SFR_RDATA  <= rd_d;
      TRACK_EN   <= state_d == ADCWIN_TRACK;
      SAR_ACTIVE <= state_d == ADCWIN_CONV;
    end
  end

  assign CONV_DONE   = done_q;
  assign DATA_OUT    = data_q;
  assign WINDOW_FLAG = flag_q;

  chk_flag_sticky: assert property (@(posedge CLOCK) disable iff (!RESETN)
    flag_q && !(wr_ctl && !SFR_WDATA[`ADCWIN_CTL_FLAG_BIT]) |=> flag_q)
    else $error("window flag dropped without a clear");
  chk_hit_sets: assert property (@(posedge CLOCK) disable iff (!RESETN)
    conv_end && hit |=> flag_q)
    else $error("window hit not flagged");
  chk_track_len: assert property (@(posedge CLOCK) disable iff (!RESETN)
    $rose(state_q == ADCWIN_TRACK) |-> (state_q == ADCWIN_TRACK) [*3] ##1 state_q == ADCWIN_CONV)
    else $error("tracking not three clocks");
  chk_conv10: assert property (@(posedge CLOCK) disable iff (!RESETN)
    $rose(state_q == ADCWIN_CONV) && !res8_q |-> ##12 conv_end)
    else $error("10-bit conversion length wrong");
  chk_conv8: assert property (@(posedge CLOCK) disable iff (!RESETN)
    $rose(state_q == ADCWIN_CONV) && res8_q |-> ##10 conv_end)
    else $error("8-bit conversion length wrong");
  chk_limit_wr: assert property (@(posedge CLOCK) disable iff (!RESETN)
    wr_uh |=> uh_q == $past(SFR_WDATA))
    else $error("upper high limit not written");
  chk_limit_lo: assert property (@(posedge CLOCK) disable iff (!RESETN)
    wr_ul |=> ul_q == $past(SFR_WDATA))
    else $error("upper low limit not written");
  chk_flag_pin: assert property (@(posedge CLOCK) disable iff (!RESETN)
    $rose(WINDOW_FLAG) |-> $past(conv_end && hit))
    else $error("flag output rose without a window hit");

  // Further guards: capture, pulse width, clearing, reset values and readback.
  chk_result_capture: assert property (@(posedge CLOCK) disable iff (!RESETN)
    conv_end |=> DATA_OUT == $past(SAR_RESULT))
    else $error("result not captured at conversion end");
  chk_done_pulse: assert property (@(posedge CLOCK) disable iff (!RESETN)
    done_q |=> !done_q)
    else $error("done pulse longer than one cycle");
  chk_flag_clear: assert property (@(posedge CLOCK) disable iff (!RESETN)
    wr_ctl && !SFR_WDATA[`ADCWIN_CTL_FLAG_BIT] && !(conv_end && hit) |=> !flag_q)
    else $error("window flag not cleared by software");
  chk_reset_limit: assert property (@(posedge CLOCK) disable iff (!RESETN)
    !$past(RESETN) |-> uh_q == `ADCWIN_RST_UPPER_HIGH && ul_q == `ADCWIN_RST_UPPER_LOW)
    else $error("upper limit not at reset value");
  chk_start_runs: assert property (@(posedge CLOCK) disable iff (!RESETN)
    start |=> state_q != ADCWIN_IDLE)
    else $error("accepted start did not begin a conversion");
  chk_low_readback: assert property (@(posedge CLOCK) disable iff (!RESETN)
    $past(sel_ul) |-> SFR_RDATA == $past(ul_q))
    else $error("upper low limit readback wrong");
endmodule : adcwin_top

// ==== rtl/adcwin_cfg.svh ====
// Constants for the converter window detector: register addresses, reset values and timing counts.
// Assumes inclusion by bare name from the top module and the testbench.
`ifndef ADCWIN_CFG_SVH
`define ADCWIN_CFG_SVH
`define ADCWIN_ADDR_UPPER_LOW  8'hc3
`define ADCWIN_ADDR_UPPER_HIGH 8'hc4
`define ADCWIN_ADDR_LOWER_LOW  8'hc5
`define ADCWIN_ADDR_LOWER_HIGH 8'hc6
`define ADCWIN_ADDR_CONTROL    8'he8
`define ADCWIN_RST_UPPER_HIGH  8'hff
`define ADCWIN_RST_UPPER_LOW   8'hff
`define ADCWIN_RST_LOWER       8'h00
`define ADCWIN_CTL_FLAG_BIT    3
`define ADCWIN_CTL_BUSY_BIT    4
`define ADCWIN_CTL_START_BIT   4
`define ADCWIN_CTL_TRACK_BIT   6
`define ADCWIN_CTL_ENABLE_BIT  7
`define ADCWIN_CTL_RES8_BIT    0
`define ADCWIN_TRACK_CLKS      4'h3
`define ADCWIN_CONV10_CLKS     4'hd
`define ADCWIN_CONV8_CLKS      4'hb
`endif

// ==== rtl/adcwin_pkg.sv ====
// Types shared by the converter control block.
// Assumes the constants header is on the include path.
package adcwin_pkg;
  typedef enum logic [1:0] {
    ADCWIN_IDLE  = 2'b00,
    ADCWIN_TRACK = 2'b01,
    ADCWIN_CONV  = 2'b10
  } adcwin_state_t;
  typedef logic [9:0] adcwin_word_t;
endpackage : adcwin_pkg

// ==== rtl/adcwin_compare.sv ====
// Window comparison of one result word against two limits.
// Assumes all inputs are on the converter clock; purely combinational.
`timescale 1ns/100ps
module adcwin_compare
  import adcwin_pkg::*;
(
  input  wire adcwin_pkg::adcwin_word_t result,
  input  wire adcwin_pkg::adcwin_word_t upper_lim,
  input  wire adcwin_pkg::adcwin_word_t lower_lim,
  output wire logic                     hit
);
  wire above = result > upper_lim;
  wire below = result < lower_lim;
  // Lower limit above upper selects the inside window, else outside.
  assign hit = (lower_lim > upper_lim) ? (above && below) : (above || below);
endmodule : adcwin_compare

// ==== tb/adcwin_testbench.sv ====
// Self-checking bench for the converter control block: limit registers, conversion timing, window flag.
// Assumes the design package and constants header are compiled first; the bench drives all ports itself.
`timescale 1ns/100ps
`include "adcwin_cfg.svh"
module testbench;
  import adcwin_pkg::*;
  logic         CLOCK     = 1'b0;
  logic         RESETN    = 1'b0;
  logic [7:0]   SFR_ADDR  = 8'h00;
  logic         SFR_WR    = 1'b0;
  logic [7:0]   SFR_WDATA = 8'h00;
  logic [7:0]   SFR_RDATA;
  adcwin_word_t SAR_RESULT = 10'h000;
  logic         TRACK_EN, SAR_ACTIVE, CONV_DONE, WINDOW_FLAG;
  adcwin_word_t DATA_OUT;
  int           errors   = 0;
  int           n_checks = 0;
  int           nt, ns;

  // Free-running converter clock.
  always #5 CLOCK = ~CLOCK;

  adcwin_top dut_u (.CLOCK(CLOCK), .RESETN(RESETN), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
    .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .SAR_RESULT(SAR_RESULT), .TRACK_EN(TRACK_EN),
    .SAR_ACTIVE(SAR_ACTIVE), .CONV_DONE(CONV_DONE), .DATA_OUT(DATA_OUT), .WINDOW_FLAG(WINDOW_FLAG));

  // Compares one observed value; four-state equality keeps unknowns from passing.
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("Checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  // One-cycle write strobe; the strobe drops a full cycle before any next write raises it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    SFR_ADDR  = a;
    SFR_WDATA = d;
    SFR_WR    = 1'b1;
    @(negedge CLOCK);
    SFR_WR    = 1'b0;
  endtask : wr

  // Read data is registered, so it is taken one cycle after the address is set.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLOCK);
    SFR_ADDR = a;
    @(negedge CLOCK);
    d = SFR_RDATA;
  endtask : rd

  // Starts a conversion and counts tracking and approximation cycles up to the done pulse.
  task automatic conv(input logic [7:0] ctl, input adcwin_word_t res);
    int i;
    nt = 0;
    ns = 0;
    SAR_RESULT = res;
    wr(`ADCWIN_ADDR_CONTROL, ctl);
    for (i = 0; i < 40; i++) begin
      if (CONV_DONE === 1'b1) break;
      nt += int'(TRACK_EN === 1'b1);
      ns += int'(SAR_ACTIVE === 1'b1);
      @(negedge CLOCK);
    end
    if (i == 40) begin
      errors++;
      stop_test();
    end
    @(negedge CLOCK);
    check("done pulse", {9'h000, CONV_DONE}, 10'h000);
  endtask : conv

  task automatic set_lim(input adcwin_word_t up, input adcwin_word_t lo);
    wr(`ADCWIN_ADDR_UPPER_HIGH, {6'h00, up[9:8]});
    wr(`ADCWIN_ADDR_UPPER_LOW, up[7:0]);
    wr(`ADCWIN_ADDR_LOWER_HIGH, {6'h00, lo[9:8]});
    wr(`ADCWIN_ADDR_LOWER_LOW, lo[7:0]);
  endtask : set_lim

  task automatic t_regs;
    logic [7:0] d;
    rd(8'hc4, d); check("upper high reset", {2'b00, d}, 10'h0ff);
    rd(8'hc3, d); check("upper low reset", {2'b00, d}, 10'h0ff);
    wr(8'hc4, 8'ha5);
    wr(8'hc3, 8'h5a);
    rd(8'hc4, d); check("upper high rw", {2'b00, d}, 10'h0a5);
    rd(8'hc3, d); check("upper low rw", {2'b00, d}, 10'h05a);
  endtask : t_regs

  task automatic t_timing;
    wr(`ADCWIN_ADDR_CONTROL, 8'hc0);
    conv(8'hd0, 10'h155);
    check("track cycles", 10'(nt), 10'd3);
    check("sar cycles 10b", 10'(ns), 10'd13);
    check("result", DATA_OUT, 10'h155);
    conv(8'hd1, 10'h0aa);
    check("sar cycles 8b", 10'(ns), 10'd11);
    wr(`ADCWIN_ADDR_CONTROL, 8'h80);
    conv(8'h90, 10'h2aa);
    check("no track", 10'(nt), 10'd0);
    check("sar cycles plain", 10'(ns), 10'd13);
  endtask : t_timing

  // Outside window first (lower below upper), then inside window with the lower limit raised above the upper.
  task automatic t_window;
    logic [7:0] d;
    set_lim(10'h100, 10'h050);
    conv(8'h90, 10'h200); check("above upper", WINDOW_FLAG, 1'b1);
    rd(`ADCWIN_ADDR_CONTROL, d); check("flag polled", d[3], 1'b1);
    conv(8'h98, 10'h080); check("sticky", WINDOW_FLAG, 1'b1);
    wr(`ADCWIN_ADDR_CONTROL, 8'h80); check("cleared", WINDOW_FLAG, 1'b0);
    conv(8'h90, 10'h080); check("inside limits", WINDOW_FLAG, 1'b0);
    conv(8'h90, 10'h040); check("below lower", WINDOW_FLAG, 1'b1);
    set_lim(10'h100, 10'h300);
    conv(8'h90, 10'h200); check("in window", WINDOW_FLAG, 1'b1);
    conv(8'h90, 10'h350); check("out of window", WINDOW_FLAG, 1'b0);
  endtask : t_window

  // Reset for twelve cycles, then the scenarios in turn.
  initial begin
    repeat (12) @(negedge CLOCK);
    RESETN = 1'b1;
    t_regs();
    t_timing();
    t_window();
    stop_test();
  end
endmodule : testbench
